// ==== pkg/backlight_cfg_pkg.sv ====
// constants and carrier types for the backlight dimming configuration registers
package backlight_cfg_pkg;

    // ********************************
    // register byte offsets
    // ********************************
    localparam logic [7:0] OFS_BRIGHTNESS_LEVEL = 8'h00;
    localparam logic [7:0] OFS_LEVEL_A_SETTING = 8'h02;
    localparam logic [7:0] OFS_DIMMING_AND_BOOST_OPTIONS = 8'h04;
    localparam logic [7:0] OFS_LED_FAULT_OPTIONS = 8'h06;

    // ********************************
    // reset values
    // ********************************
    localparam logic [15:0] RST_BRIGHTNESS_LEVEL = 16'h0000;
    localparam logic [15:0] RST_LEVEL_A_SETTING = 16'h0FFF;
    localparam logic [15:0] RST_DIMMING_AND_BOOST_OPTIONS = 16'h08A3;
    localparam logic [15:0] RST_LED_FAULT_OPTIONS = 16'h0100;

    // ********************************
    // field positions (lsb)
    // ********************************
    localparam int LEVEL_A_LSB = 0;
    localparam int LEVEL_A_W = 12;
    localparam int PSEUDO_EN_BIT = 14;
    localparam int SPREAD_RATE_LSB = 12;
    localparam int SPREAD_RANGE_LSB = 10;
    localparam int SOURCE_SELECT_LSB = 8;
    localparam int RAMP_SELECT_LSB = 5;
    localparam int DITHER_LSB = 2;
    localparam int SMOOTH_RAMP_BIT = 1;

    // ********************************
    // field codes
    // ********************************
    localparam logic [1:0] SRC_PWM_INPUT = 2'h0;
    localparam logic [1:0] SRC_REGISTER = 2'h2;
    localparam logic [2:0] DITHER_MAX = 3'h4;

    // ********************************
    // ramp durations in ms for linear ramping, codes 1..7
    // ********************************
    localparam logic [9:0] RAMP_MS_1 = 10'd1;
    localparam logic [9:0] RAMP_MS_2 = 10'd2;
    localparam logic [9:0] RAMP_MS_3 = 10'd50;
    localparam logic [9:0] RAMP_MS_4 = 10'd100;
    localparam logic [9:0] RAMP_MS_5 = 10'd200;
    localparam logic [9:0] RAMP_MS_6 = 10'd300;
    localparam logic [9:0] RAMP_MS_7 = 10'd500;

    // spread range in tenths of a percent, modulation rate in Hz
    localparam logic [6:0] SPREAD_RANGE_0 = 7'd33;
    localparam logic [6:0] SPREAD_RANGE_1 = 7'd43;
    localparam logic [6:0] SPREAD_RANGE_2 = 7'd53;
    localparam logic [6:0] SPREAD_RANGE_3 = 7'd72;
    localparam logic [10:0] SPREAD_RATE_0 = 11'd200;
    localparam logic [10:0] SPREAD_RATE_1 = 11'd500;
    localparam logic [10:0] SPREAD_RATE_2 = 11'd800;
    localparam logic [10:0] SPREAD_RATE_3 = 11'd1200;

    // ********************************
    // serial link state machine
    // ********************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_ACK = 6'b000100,
        ST_RX = 6'b001000,
        ST_TX = 6'b010000,
        ST_RACK = 6'b100000
    } link_state_t;

    // decoded settings handed to the dimming and boost datapaths
    typedef struct packed {
        logic [11:0] level_a;
        logic [15:0] brightness_target;
        logic source_is_register;
        logic ramp_enable;
        logic [10:0] ramp_ms;
        logic smooth_ramp_enable;
        logic [2:0] dither_bits;
        logic [6:0] spread_range_tenths;
        logic [10:0] boost_spread_rate_hz;
        logic pseudo_random_enable;
        logic [15:0] led_fault_options;
    } cfg_t;

endpackage : backlight_cfg_pkg

// ==== hdl/backlight_dimming_config_regs.sv ====
// serial-accessed configuration registers for Level_a, dimming and boost spread
`timescale 1ns/1ps
module backlight_dimming_config_regs
    import backlight_cfg_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h2C // arbitrary value
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic write_allowed,
    input wire logic [15:0] pwm_duty,
    output cfg_t cfg
);
    // ********************************
    // reset release and pin synchronisers
    // ********************************
    logic rst_meta_r, rst_n_r;
    logic scl_meta_r, scl_r, scl_d_r;
    logic sda_meta_r, sda_r, sda_d_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end
    // both pins idle high, so no false edge follows reset
    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            {scl_d_r, scl_r, scl_meta_r} <= 3'b111;
            {sda_d_r, sda_r, sda_meta_r} <= 3'b111;
        end else if (ce) begin
            {scl_d_r, scl_r, scl_meta_r} <= {scl_r, scl_meta_r, scl_i};
            {sda_d_r, sda_r, sda_meta_r} <= {sda_r, sda_meta_r, sda_i};
        end
    end
    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl_r & ~scl_d_r;
    assign scl_fall = ~scl_r & scl_d_r;
    assign start_seen = scl_r & scl_d_r & sda_d_r & ~sda_r;
    assign stop_seen = scl_r & scl_d_r & ~sda_d_r & sda_r;
    // ********************************
    // register file and link state
    // ********************************
    logic [15:0] brt_r, brt_nxt;
    logic [15:0] cur_r, cur_nxt;
    logic [15:0] opt_r, opt_nxt;
    logic [15:0] flt_r, flt_nxt;
    link_state_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic rw_r, rw_nxt;
    logic first_r, first_nxt;
    logic mack_r, mack_nxt;
    logic oe_r, oe_nxt;

    // byte view: even address low byte, odd address high byte
    function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [15:0] b,
                                             input logic [15:0] c, input logic [15:0] o,
                                             input logic [15:0] f);
        logic [15:0] w;
        w = 16'h0000;
        if ({a[7:1], 1'b0} == OFS_BRIGHTNESS_LEVEL) begin
            w = b;
        end else if ({a[7:1], 1'b0} == OFS_LEVEL_A_SETTING) begin
            w = c;
        end else if ({a[7:1], 1'b0} == OFS_DIMMING_AND_BOOST_OPTIONS) begin
            w = o;
        end else if ({a[7:1], 1'b0} == OFS_LED_FAULT_OPTIONS) begin
            w = f;
        end
        return a[0] ? w[15:8] : w[7:0];
    endfunction : read_byte
    always_comb begin
        logic [7:0] wa;
        wa = {ptr_r[7:1], 1'b0};
        brt_nxt = brt_r;
        cur_nxt = cur_r;
        opt_nxt = opt_r;
        flt_nxt = flt_r;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        first_nxt = first_r;
        mack_nxt = mack_r;
        oe_nxt = oe_r;
        if (stop_seen) begin
            st_nxt = ST_IDLE;
            oe_nxt = 1'b0;
        end else if (start_seen) begin
            st_nxt = ST_ADDR;
            cnt_nxt = 4'h0;
            first_nxt = 1'b1;
            oe_nxt = 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    oe_nxt = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_r};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == 4'h8) begin
                        oe_nxt = 1'b1;
                        st_nxt = ST_ACK;
                        if (st_r == ST_ADDR) begin
                            rw_nxt = sh_r[0];
                            if (sh_r[7:1] != DEVICE_ADDR) begin
                                oe_nxt = 1'b0;
                                st_nxt = ST_IDLE;
                            end
                        end else if (first_r) begin
                            ptr_nxt = sh_r;
                            first_nxt = 1'b0;
                        end else begin
                            ptr_nxt = ptr_r + 8'h01;
                            if (write_allowed) begin
                                // all fields plain read/write, reserved bits kept as written
                                if (wa == OFS_BRIGHTNESS_LEVEL) begin
                                    brt_nxt[{ptr_r[0], 3'b000} +: 8] = sh_r;
                                end else if (wa == OFS_LEVEL_A_SETTING) begin
                                    cur_nxt[{ptr_r[0], 3'b000} +: 8] = sh_r;
                                end else if (wa == OFS_DIMMING_AND_BOOST_OPTIONS) begin
                                    opt_nxt[{ptr_r[0], 3'b000} +: 8] = sh_r;
                                end else if (wa == OFS_LED_FAULT_OPTIONS) begin
                                    flt_nxt[{ptr_r[0], 3'b000} +: 8] = sh_r;
                                end
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (rw_r) begin
                            sh_nxt = read_byte(ptr_r, brt_r, cur_r, opt_r, flt_r);
                            oe_nxt = ~sh_nxt[7];
                            st_nxt = ST_TX;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_r == 4'h7) begin
                            oe_nxt = 1'b0;
                            ptr_nxt = ptr_r + 8'h01;
                            st_nxt = ST_RACK;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_nxt = ~sh_r[6];
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        mack_nxt = ~sda_r;
                    end else if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (mack_r) begin
                            sh_nxt = read_byte(ptr_r, brt_r, cur_r, opt_r, flt_r);
                            oe_nxt = ~sh_nxt[7];
                            st_nxt = ST_TX;
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            brt_r <= RST_BRIGHTNESS_LEVEL;
            cur_r <= RST_LEVEL_A_SETTING;
            opt_r <= RST_DIMMING_AND_BOOST_OPTIONS;
            flt_r <= RST_LED_FAULT_OPTIONS;
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            mack_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (ce) begin
            brt_r <= brt_nxt;
            cur_r <= cur_nxt;
            opt_r <= opt_nxt;
            flt_r <= flt_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            first_r <= first_nxt;
            mack_r <= mack_nxt;
            oe_r <= oe_nxt;
        end
    end

    // ********************************
    // field decode toward the datapaths
    // ********************************
    cfg_t cfg_r, cfg_nxt;
    logic sda_o_r;

    always_comb begin
        logic [1:0] src;
        logic [2:0] rsel;
        logic [2:0] dsel;
        logic [9:0] lin_ms;
        lin_ms = 10'h000;
        src = opt_r[SOURCE_SELECT_LSB +: 2];
        rsel = opt_r[RAMP_SELECT_LSB +: 3];
        dsel = opt_r[DITHER_LSB +: 3];
        cfg_nxt = '0;
        cfg_nxt.level_a = cur_r[LEVEL_A_LSB +: LEVEL_A_W];
        // reserved source codes fall back to the pwm input
        cfg_nxt.source_is_register = (src == SRC_REGISTER);
        cfg_nxt.brightness_target = (src == SRC_REGISTER) ? brt_r : pwm_duty;
        case (rsel)
            3'h1: lin_ms = RAMP_MS_1;
            3'h2: lin_ms = RAMP_MS_2;
            3'h3: lin_ms = RAMP_MS_3;
            3'h4: lin_ms = RAMP_MS_4;
            3'h5: lin_ms = RAMP_MS_5;
            3'h6: lin_ms = RAMP_MS_6;
            3'h7: lin_ms = RAMP_MS_7;
            default: lin_ms = 10'd0;
        endcase
        cfg_nxt.ramp_enable = (rsel != 3'h0);
        cfg_nxt.smooth_ramp_enable = opt_r[SMOOTH_RAMP_BIT];
        // advanced ramps run twice the linear time; 1/2 ms codes still decode
        cfg_nxt.ramp_ms = opt_r[SMOOTH_RAMP_BIT] ? {lin_ms, 1'b0} : {1'b0, lin_ms};
        // over-range dither codes are clamped so the datapath never sees them
        cfg_nxt.dither_bits = (dsel > DITHER_MAX) ? DITHER_MAX : dsel;
        case (opt_r[SPREAD_RANGE_LSB +: 2])
            2'h0: cfg_nxt.spread_range_tenths = SPREAD_RANGE_0;
            2'h1: cfg_nxt.spread_range_tenths = SPREAD_RANGE_1;
            2'h2: cfg_nxt.spread_range_tenths = SPREAD_RANGE_2;
            default: cfg_nxt.spread_range_tenths = SPREAD_RANGE_3;
        endcase
        case (opt_r[SPREAD_RATE_LSB +: 2])
            2'h0: cfg_nxt.boost_spread_rate_hz = SPREAD_RATE_0;
            2'h1: cfg_nxt.boost_spread_rate_hz = SPREAD_RATE_1;
            2'h2: cfg_nxt.boost_spread_rate_hz = SPREAD_RATE_2;
            default: cfg_nxt.boost_spread_rate_hz = SPREAD_RATE_3;
        endcase
        cfg_nxt.pseudo_random_enable = opt_r[PSEUDO_EN_BIT];
        cfg_nxt.led_fault_options = flt_r;
    end

    always_ff @(posedge mclk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_r <= '0;
            sda_o_r <= 1'b0;
        end else if (ce) begin
            cfg_r <= cfg_nxt;
            sda_o_r <= 1'b0;
        end
    end
    assign cfg = cfg_r;
    assign sda_o = sda_o_r;
    assign sda_oe = oe_r;
endmodule : backlight_dimming_config_regs

// ==== verification/serial_host_model.sv ====
// serial register host model: drives the clock line and pulls data low
`timescale 1ns/1ps
module serial_host_model #(
    parameter logic [6:0] DEV = 7'h2C // arbitrary value
) (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_n
    // data moves four mclk cycles after scl falls, never beside an scl edge
    task automatic put(input logic b);
        wait_n(4);
        sda_oe <= !b;
        wait_n(8);
        scl <= 1'b1;
        wait_n(8);
        scl <= 1'b0;
    endtask : put
    task automatic get(output logic b);
        wait_n(4);
        sda_oe <= 1'b0;
        wait_n(8);
        scl <= 1'b1;
        wait_n(8);
        b = sda;
        scl <= 1'b0;
    endtask : get
    task automatic start();
        wait_n(4);
        sda_oe <= 1'b0;
        wait_n(8);
        scl <= 1'b1;
        wait_n(8);
        sda_oe <= 1'b1;
        wait_n(8);
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        wait_n(4);
        sda_oe <= 1'b1;
        wait_n(8);
        scl <= 1'b1;
        wait_n(8);
        sda_oe <= 1'b0;
        wait_n(8);
    endtask : stop
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic nak;
        for (int i = 7; i >= 0; i--) begin
            put(b[i]);
        end
        get(nak);
        ack = !nak;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            get(b[i]);
        end
        put(last);
    endtask : rbyte
    // low byte first: even offset holds bits 7..0
    task automatic wr16(input logic [6:0] dev, input logic [7:0] p, input logic [15:0] d,
                        output logic ok);
        logic a0, a1, a2, a3;
        start();
        wbyte({dev, 1'b0}, a0);
        wbyte(p, a1);
        wbyte(d[7:0], a2);
        wbyte(d[15:8], a3);
        stop();
        ok = a0 & a1 & a2 & a3;
    endtask : wr16
    task automatic rd16(input logic [7:0] p, output logic [15:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({DEV, 1'b0}, a0);
        wbyte(p, a1);
        start();
        wbyte({DEV, 1'b1}, a2);
        rbyte(1'b0, d[7:0]);
        rbyte(1'b1, d[15:8]);
        stop();
        ok = a0 & a1 & a2;
    endtask : rd16
endmodule : serial_host_model

// ==== verification/backlight_cfg_chk.sv ====
// assertion checker on the ports of the configuration register bank
`timescale 1ns/1ps
module backlight_cfg_chk
    import backlight_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sda_oe,
    input wire logic write_allowed,
    input wire logic [15:0] pwm_duty,
    input wire cfg_t cfg
);
    // cfg is zero while the internal reset copy is still low
    logic [2:0] up_r;
    logic [2:0] up_nxt;
    logic ok;
    always_comb begin
        up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            up_r <= 3'h0;
        end else begin
            up_r <= up_nxt;
        end
    end
    assign ok = (up_r == 3'h7);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_reset_decode: assert property (
        up_r == 3'h6 |-> cfg.level_a == 12'hFFF && cfg.ramp_ms == 11'h190
        && cfg.smooth_ramp_enable && cfg.dither_bits == 3'h0 && !cfg.pseudo_random_enable
        && cfg.spread_range_tenths == 7'h35 && cfg.boost_spread_rate_hz == 11'h0C8
        && !cfg.source_is_register && cfg.led_fault_options == 16'h0100)
        else $error("decoded reset settings wrong");
    a_linear_ms: assert property (
        cfg.ramp_enable && !cfg.smooth_ramp_enable |-> cfg.ramp_ms inside
        {11'h001, 11'h002, 11'h032, 11'h064, 11'h0C8, 11'h12C, 11'h1F4})
        else $error("linear ramp duration off table");
    a_smooth_ms: assert property (
        cfg.ramp_enable && cfg.smooth_ramp_enable |-> cfg.ramp_ms inside
        {11'h064, 11'h0C8, 11'h190, 11'h258, 11'h3E8})
        else $error("advanced ramp duration off table");
    a_ramp_off: assert property (
        !cfg.ramp_enable |-> cfg.ramp_ms == 11'h000)
        else $error("ramp time with ramping off");
    a_dither_cap: assert property (
        cfg.dither_bits <= 3'h4)
        else $error("dither depth above four");
    a_range_set: assert property (
        ok |-> cfg.spread_range_tenths inside {7'h21, 7'h2B, 7'h35, 7'h48})
        else $error("spread range off table");
    a_rate_set: assert property (
        ok |-> cfg.boost_spread_rate_hz inside {11'h0C8, 11'h1F4, 11'h320, 11'h4B0})
        else $error("spread rate off table");
    a_pwm_source: assert property (
        ok && !cfg.source_is_register |-> cfg.brightness_target == $past(pwm_duty))
        else $error("target not following pwm duty");
    a_blocked_hold: assert property (
        ok && !$past(write_allowed, 2) |-> $stable(cfg.level_a)
        && $stable(cfg.dither_bits) && $stable(cfg.led_fault_options))
        else $error("settings changed while writes blocked");
    a_ack_stands: assert property (
        $rose(sda_oe) |-> sda_oe [*8])
        else $error("data pull-down too short");
endmodule : backlight_cfg_chk

// ==== verification/backlight_dimming_config_regs_tb.sv ====
// self-checking bench for the backlight configuration register bank
`timescale 1ns/1ps
module backlight_dimming_config_regs_tb
    import backlight_cfg_pkg::*;
;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic write_allowed = 1'b1;
    logic [15:0] pwm_duty = 16'h0000;
    logic scl;
    logic host_oe;
    logic sda_o;
    logic sda_oe;
    wire sda;
    cfg_t cfg;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] rd;
    logic ok;
    logic [10:0] ramp_tab [8] = '{11'h000, 11'h001, 11'h002, 11'h032, 11'h064, 11'h0C8,
                                  11'h12C, 11'h1F4};
    logic [6:0] range_tab [4] = '{7'h21, 7'h2B, 7'h35, 7'h48};
    logic [10:0] rate_tab [4] = '{11'h0C8, 11'h1F4, 11'h320, 11'h4B0};
    // open drain with pull-up: low when either side pulls
    assign sda = !(sda_oe || host_oe);
    always #25 mclk = ~mclk;
    backlight_dimming_config_regs dut (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .write_allowed(write_allowed), .pwm_duty(pwm_duty), .cfg(cfg));
    serial_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sda_oe(host_oe));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            failures++;
            $display("FAIL run length expected 80000 seen more");
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        host.wr16(7'h2C, p, d, ok);
        check("write ack", 16'h0001, {15'h0, ok});
    endtask : wr
    task automatic rdc(input string what, input logic [7:0] p, input logic [15:0] exp);
        host.rd16(p, rd, ok);
        check("read ack", 16'h0001, {15'h0, ok});
        check(what, exp, rd);
    endtask : rdc
    task automatic test_reset();
        rdc("brightness reset", OFS_BRIGHTNESS_LEVEL, 16'h0000);
        rdc("current reset", OFS_LEVEL_A_SETTING, 16'h0FFF);
        rdc("options reset", OFS_DIMMING_AND_BOOST_OPTIONS, 16'h08A3);
        rdc("fault reset", OFS_LED_FAULT_OPTIONS, 16'h0100);
        check("level_a reset", 16'h0FFF, {4'h0, cfg.level_a});
        check("sda drive level", 16'h0000, {15'h0, sda_o});
        $display("test_reset done");
    endtask : test_reset
    task automatic test_current();
        wr(OFS_LEVEL_A_SETTING, 16'hA5C3);
        rdc("current rw", OFS_LEVEL_A_SETTING, 16'hA5C3);
        check("level_a", 16'h05C3, {4'h0, cfg.level_a});
        wr(OFS_BRIGHTNESS_LEVEL, 16'h1234);
        rdc("brightness rw", OFS_BRIGHTNESS_LEVEL, 16'h1234);
        $display("test_current done");
    endtask : test_current
    task automatic test_options();
        logic [15:0] v;
        logic [2:0] dith;
        for (int sm = 0; sm < 2; sm++) begin
            for (int k = 0; k < 8; k++) begin
                if (sm == 1 && (k == 1 || k == 2)) continue;
                dith = (k > 4) ? 3'(k - 4) : 3'(k);
                v = {1'b0, k[0], k[2:1], k[1:0], sm[0] ? SRC_REGISTER : SRC_PWM_INPUT,
                     k[2:0], dith, sm[0], 1'b1};
                pwm_duty <= 16'hBE00 + 16'(k);
                wr(OFS_DIMMING_AND_BOOST_OPTIONS, v);
                rdc("options rw", OFS_DIMMING_AND_BOOST_OPTIONS, v);
                check("ramp_ms", {5'h0, ramp_tab[k] << sm}, {5'h0, cfg.ramp_ms});
                check("ramp_enable", {15'h0, k != 0}, {15'h0, cfg.ramp_enable});
                check("smooth", 16'(sm), {15'h0, cfg.smooth_ramp_enable});
                check("dither", {13'h0, dith}, {13'h0, cfg.dither_bits});
                check("range", {9'h0, range_tab[k[1:0]]}, {9'h0, cfg.spread_range_tenths});
                check("rate", {5'h0, rate_tab[k[2:1]]}, {5'h0, cfg.boost_spread_rate_hz});
                check("pseudo", {15'h0, k[0]}, {15'h0, cfg.pseudo_random_enable});
                check("target", sm[0] ? 16'h1234 : 16'hBE00 + 16'(k),
                      cfg.brightness_target);
            end
        end
        $display("test_options done");
    endtask : test_options
    task automatic test_blocked();
        write_allowed <= 1'b0;
        wr(OFS_LEVEL_A_SETTING, 16'h0123);
        rdc("blocked write", OFS_LEVEL_A_SETTING, 16'hA5C3);
        check("level_a held", 16'h05C3, {4'h0, cfg.level_a});
        write_allowed <= 1'b1;
        $display("test_blocked done");
    endtask : test_blocked
    task automatic test_refusals();
        host.wr16(7'h2D, OFS_LEVEL_A_SETTING, 16'h0777, ok);
        check("foreign address ack", 16'h0000, {15'h0, ok});
        rdc("foreign write dropped", OFS_LEVEL_A_SETTING, 16'hA5C3);
        wr(8'h08, 16'hFFFF);
        rdc("unmapped read", 8'h08, 16'h0000);
        $display("test_refusals done");
    endtask : test_refusals
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (10) @(posedge mclk);
        test_reset();
        test_current();
        test_options();
        test_blocked();
        test_refusals();
        tally_and_finish();
    end
endmodule : backlight_dimming_config_regs_tb
bind backlight_dimming_config_regs backlight_cfg_chk chk (.mclk(mclk), .reset_n(reset_n),
    .sda_oe(sda_oe), .write_allowed(write_allowed), .pwm_duty(pwm_duty), .cfg(cfg));
